/* include/burst_fetch_pkg.sv */
`default_nettype none
package burst_fetch_pkg;
    // address geometry, word addresses
    localparam int unsigned MEM_ADDR_W  = 17;
    localparam int unsigned CNT_W       = 8;
    localparam int unsigned UPPER_W     = MEM_ADDR_W - CNT_W;
    localparam int unsigned MAX_BURST   = 256;
    localparam int unsigned BURST_LEN_W = 9;
    localparam int unsigned SMALL_MEM_W = 11;

    // reset values, acknowledge mode default and burst length limit
    localparam logic ACC_IDLE     = 1'b0;
    localparam logic STROBE_OFF   = 1'b1;
    localparam logic ACK_ALWAYS   = 1'b0;
    localparam logic [CNT_W-1:0]   CNT_RESET   = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_RESET = 9'h000;
    localparam logic [BURST_LEN_W-1:0] LEN_RESET = 9'h000;
    localparam logic [BURST_LEN_W-1:0] LEN_MAX   = 9'h100;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_REQ,
        HOST_BURST,
        HOST_PAUSE
    } host_state_e;
endpackage
`default_nettype wire

/* include/instr_bus_if.sv */
`default_nettype none
interface instr_bus_if;
    import burst_fetch_pkg::*;
    logic                  instrReq_n;
    logic                  burstReq_n;
    logic                  busInv_n;
    logic [MEM_ADDR_W-1:0] instrAddr;
    logic                  burstAck_n;
    logic                  instr_valid_n;

    modport ctrl (
        input  instrReq_n,
        input  burstReq_n,
        input  busInv_n,
        input  instrAddr,
        output burstAck_n,
        output instr_valid_n
    );

    modport cpu (
        output instrReq_n,
        output burstReq_n,
        output busInv_n,
        output instrAddr,
        input  burstAck_n,
        input  instr_valid_n
    );
endinterface
`default_nettype wire

/* design/addr_counter_latch.sv */
`default_nettype none
module addr_counter_latch
    import burst_fetch_pkg::*;
#(
    parameter int unsigned LATCH_W = UPPER_W
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  load,
    input  wire logic                  incr,
    input  wire logic [CNT_W-1:0]      lowIn,
    input  wire logic [LATCH_W-1:0]    upperIn,
    output logic      [CNT_W-1:0]      lowCnt,
    output logic      [LATCH_W-1:0]    upperLatch
);

    ////////////////////////////////////////////////////////////////////////
    // low counter: load, increment, else hold
    always_ff @(posedge clock) begin
        if (srst) begin
            lowCnt <= CNT_RESET;
        end else if (load) begin
            lowCnt <= lowIn;
        end else if (incr) begin
            lowCnt <= lowCnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // upper latch, no carry in from the counter
    always_ff @(posedge clock) begin
        if (srst) begin
            upperLatch <= LATCH_W'(UPPER_RESET);
        end else if (load) begin
            upperLatch <= upperIn;
        end
    end

endmodule
`default_nettype wire

/* design/burst_fetch_ctrl.sv */
// Operation
// - all instruction strobes are active low
// - one registered bit holds fetch state
// - state bit drives chip enable, valid
// - idle plus request, no invalidate: start
// - stay active while burst request held
// - burst request alone resumes without loading
// - acknowledge is registered copy of request
// - dropped acknowledge ends burst; re-request (cpu instead goes idle via HOST_PAUSE, flags burstLost)
// - optionally hold acknowledge permanently asserted
// - processor asks burst via burst request
// - low eight bits counter loads address
// - counter increments each clock while active
// - upper bits latched on load, else held
// - processor bursts at most 256 words
// - latch width follows memory size
// - invalidate cancels; no access started
// - valid only with memory word present
// - load only idle with request, no invalidate
// - resume also needs invalidate deasserted
// - latch reloads under counter load condition
`default_nettype none
module burst_fetch_ctrl
    import burst_fetch_pkg::*;
#(
    parameter logic ACK_HOLD = ACK_ALWAYS
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    instr_bus_if.ctrl                  bus,
    output logic      [MEM_ADDR_W-1:0] romAddr,
    output logic                       romCe_n,
    output logic                       romOe_n,
    output logic                       accessActive,
    output logic                       loadPulse,
    output logic                       resumePulse,
    output logic      [BURST_LEN_W-1:0] burstLen,
    output logic                       burstOverrun
);

    ////////////////////////////////////////////////////////////////////////
    // strobe decode, active low at the pins

    function automatic logic startCond(input logic req_n, input logic inv_n, input logic acc);
        startCond = !acc && !req_n && inv_n;
    endfunction

    function automatic logic resumeCond(input logic req_n, input logic breq_n, input logic inv_n,
                                        input logic acc);
        resumeCond = !acc && req_n && !breq_n && inv_n;
    endfunction

    logic accActive_r;
    logic accActive_nxt;
    logic loadNow;
    logic resumeNow;
    logic burstAck_n_r;
    logic instrValid_n_r;
    logic romCe_n_r;
    logic romOe_n_r;
    logic loadPulse_r;
    logic resumePulse_r;
    logic [BURST_LEN_W-1:0] burstLen_r;
    logic burstOverrun_r;
    logic [CNT_W-1:0] lowCnt;
    logic [UPPER_W-1:0] upperLatch;

    assign loadNow   = startCond(bus.instrReq_n, bus.busInv_n, accActive_r);
    assign resumeNow = resumeCond(bus.instrReq_n, bus.burstReq_n, bus.busInv_n, accActive_r);

    ////////////////////////////////////////////////////////////////////////
    // access state bit

    always_comb begin
        accActive_nxt = ACC_IDLE;
        if (loadNow) begin
            accActive_nxt = 1'b1;
        end else if (resumeNow) begin
            accActive_nxt = 1'b1;
        end else if (accActive_r && !bus.burstReq_n) begin
            accActive_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            accActive_r <= ACC_IDLE;
        end else begin
            accActive_r <= accActive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins driven from the access bit; copies track it edge for edge

    always_ff @(posedge clock) begin
        if (srst) begin
            instrValid_n_r <= STROBE_OFF;
            romCe_n_r      <= STROBE_OFF;
            romOe_n_r      <= STROBE_OFF;
        end else begin
            instrValid_n_r <= ~accActive_nxt;
            romCe_n_r      <= ~accActive_nxt;
            romOe_n_r      <= ~accActive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst acknowledge

    always_ff @(posedge clock) begin
        if (srst) begin
            burstAck_n_r <= STROBE_OFF;
        end else if (ACK_HOLD) begin
            burstAck_n_r <= 1'b0;
        end else begin
            burstAck_n_r <= bus.burstReq_n;
        end
    end

    assign bus.burstAck_n    = burstAck_n_r;
    assign bus.instr_valid_n = instrValid_n_r;

    ////////////////////////////////////////////////////////////////////////
    // address counter and upper latch

    addr_counter_latch #(
        .LATCH_W (UPPER_W)
    ) u_addr (
        .clock      (clock),
        .srst       (srst),
        .load       (loadNow),
        .incr       (accActive_r),
        .lowIn      (bus.instrAddr[CNT_W-1:0]),
        .upperIn    (bus.instrAddr[MEM_ADDR_W-1:CNT_W]),
        .lowCnt     (lowCnt),
        .upperLatch (upperLatch)
    );

    ////////////////////////////////////////////////////////////////////////
    // event pulses for the user side

    always_ff @(posedge clock) begin
        if (srst) begin
            loadPulse_r   <= 1'b0;
            resumePulse_r <= 1'b0;
        end else begin
            loadPulse_r   <= loadNow;
            resumePulse_r <= resumeNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // words since the last load; more than the limit means the counter wrapped

    always_ff @(posedge clock) begin
        if (srst) begin
            burstLen_r <= LEN_RESET;
        end else if (loadNow) begin
            burstLen_r <= LEN_RESET;
        end else if (accActive_r && burstLen_r != LEN_MAX) begin
            burstLen_r <= burstLen_r + 9'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            burstOverrun_r <= 1'b0;
        end else if (accActive_r && burstLen_r == LEN_MAX) begin
            burstOverrun_r <= 1'b1;
        end else if (loadNow) begin
            burstOverrun_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user-side outputs

    assign romAddr      = {upperLatch, lowCnt};
    assign romCe_n      = romCe_n_r;
    assign romOe_n      = romOe_n_r;
    assign accessActive = accActive_r;
    assign loadPulse    = loadPulse_r;
    assign resumePulse  = resumePulse_r;
    assign burstLen     = burstLen_r;
    assign burstOverrun = burstOverrun_r;

endmodule
`default_nettype wire

/* design/burst_fetch_cpu.sv */
`default_nettype none
module burst_fetch_cpu
    import burst_fetch_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  srst,
    instr_bus_if.cpu                   bus,
    input  wire logic                  fetchStart,
    input  wire logic [MEM_ADDR_W-1:0] fetchAddr,
    input  wire logic                  fetchBurst,
    input  wire logic                  fetchCancel,
    output logic                       wordValid,
    output logic                       burstLost,
    output logic                       busy
);

    host_state_e state_r;
    logic reqN_r;
    logic breqN_r;
    logic invN_r;
    logic [MEM_ADDR_W-1:0] addr_r;
    logic wordValid_r;
    logic burstLost_r;
    logic [BURST_LEN_W-1:0] beats_r;
    logic lastBeat;

    assign lastBeat = (beats_r == LEN_MAX - 9'h002);

    ////////////////////////////////////////////////////////////////////////
    // request sequencing
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= HOST_IDLE;
            reqN_r  <= STROBE_OFF;
            breqN_r <= STROBE_OFF;
            invN_r  <= STROBE_OFF;
            addr_r  <= '0;
            beats_r <= LEN_RESET;
        end else begin
            invN_r <= ~fetchCancel;
            case (state_r)
                HOST_IDLE: begin
                    // a cancelled start still strobes, under invalidate
                    if (fetchStart) begin
                        reqN_r  <= 1'b0;
                        breqN_r <= ~(fetchBurst && !fetchCancel);
                        addr_r  <= fetchAddr;
                        beats_r <= LEN_RESET;
                        state_r <= HOST_REQ;
                    end
                end
                HOST_REQ: begin
                    reqN_r  <= STROBE_OFF;
                    state_r <= breqN_r ? HOST_IDLE : HOST_BURST;
                    if (breqN_r) begin
                        breqN_r <= STROBE_OFF;
                    end
                end
                HOST_BURST: begin
                    beats_r <= beats_r + 9'h001;
                    if (!fetchBurst || fetchCancel || lastBeat) begin
                        breqN_r <= STROBE_OFF;
                        state_r <= HOST_IDLE;
                    end else if (bus.burstAck_n) begin
                        breqN_r <= STROBE_OFF;
                        state_r <= HOST_PAUSE;
                    end
                end
                HOST_PAUSE: begin
                    state_r <= HOST_IDLE;
                end
                default: begin
                    state_r <= HOST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status
    always_ff @(posedge clock) begin
        if (srst) begin
            wordValid_r <= 1'b0;
            burstLost_r <= 1'b0;
        end else begin
            wordValid_r <= ~bus.instr_valid_n;
            if (state_r == HOST_BURST && bus.burstAck_n && fetchBurst) begin
                burstLost_r <= 1'b1;
            end else if (fetchStart) begin
                burstLost_r <= 1'b0;
            end
        end
    end

    assign bus.instrReq_n = reqN_r;
    assign bus.burstReq_n = breqN_r;
    assign bus.busInv_n   = invN_r;
    assign bus.instrAddr  = addr_r;
    assign wordValid      = wordValid_r;
    assign burstLost      = burstLost_r;
    assign busy           = (state_r != HOST_IDLE);

endmodule
`default_nettype wire

/* verification/burst_fetch_assertions.sv */
`default_nettype none
module burst_fetch_assertions
    import burst_fetch_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic                  instrReq_n,
    input wire logic                  burstReq_n,
    input wire logic                  busInv_n,
    input wire logic [MEM_ADDR_W-1:0] instrAddr,
    input wire logic                  burstAck_n,
    input wire logic                  instr_valid_n
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    AST_START: assert property (
        instr_valid_n && !instrReq_n && busInv_n |=> !instr_valid_n)
        else $error("access did not start on request");
    AST_STAY: assert property (
        !instr_valid_n ##0 !burstReq_n[*2] |=> !instr_valid_n)
        else $error("access left while burst held");
    AST_EXIT: assert property (
        !instr_valid_n && burstReq_n |=> instr_valid_n)
        else $error("access kept without burst request");
    AST_RESUME: assert property (
        instr_valid_n && instrReq_n && !burstReq_n && busInv_n |=> !instr_valid_n)
        else $error("burst resume not entered");
    AST_INV: assert property (
        instr_valid_n && !busInv_n |=> instr_valid_n)
        else $error("access started under invalidate");
    AST_ACK: assert property (
        !$past(srst) |-> burstAck_n == $past(burstReq_n))
        else $error("acknowledge is not registered burst request");
    AST_RESET: assert property (
        $past(srst) |-> instr_valid_n && burstAck_n)
        else $error("strobes active after reset");
    AST_IDLE_HOLD: assert property (
        instr_valid_n && instrReq_n && burstReq_n |=> instr_valid_n)
        else $error("valid without any request");
endmodule
`default_nettype wire

/* verification/burst_fetch_ctrl_tb.sv */
`default_nettype none
module burst_fetch_ctrl_tb;
    import burst_fetch_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clock;
    logic                  srst;
    logic                  fetchStart;
    logic [MEM_ADDR_W-1:0] fetchAddr;
    logic                  fetchBurst;
    logic                  fetchCancel;
    logic                  wordValid;
    logic                  busy;
    logic [MEM_ADDR_W-1:0] romAddr;
    logic                  romCe_n;
    logic                  accessActive;
    logic                  romOe_n;
    logic                  loadPulse;
    logic                  resumePulse;
    logic [BURST_LEN_W-1:0] burstLen;
    logic [BURST_LEN_W-1:0] expLen;
    logic                  burstOverrun;
    logic                  burstLost;
    logic [MEM_ADDR_W-1:0] expQ[$];
    logic [MEM_ADDR_W-1:0] expAddr;
    logic                  prevAct;
    logic [15:0]           lfsr;
    int                    fails;
    int                    checksDone;

    instr_bus_if bus ();

    burst_fetch_cpu i_burst_fetch_cpu (
        .clock       (clock),
        .srst        (srst),
        .bus         (bus.cpu),
        .fetchStart  (fetchStart),
        .fetchAddr   (fetchAddr),
        .fetchBurst  (fetchBurst),
        .fetchCancel (fetchCancel),
        .wordValid   (wordValid),
        .burstLost   (burstLost),
        .busy        (busy)
    );

    burst_fetch_ctrl i_burst_fetch_ctrl (
        .clock        (clock),
        .srst         (srst),
        .bus          (bus.ctrl),
        .romAddr      (romAddr),
        .romCe_n      (romCe_n),
        .romOe_n      (romOe_n),
        .accessActive (accessActive),
        .loadPulse    (loadPulse),
        .resumePulse  (resumePulse),
        .burstLen     (burstLen),
        .burstOverrun (burstOverrun)
    );

    burst_fetch_assertions i_burst_fetch_assertions (
        .clock         (clock),
        .srst          (srst),
        .instrReq_n    (bus.instrReq_n),
        .burstReq_n    (bus.burstReq_n),
        .busInv_n      (bus.busInv_n),
        .instrAddr     (bus.instrAddr),
        .burstAck_n    (bus.burstAck_n),
        .instr_valid_n (bus.instr_valid_n)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsrNext(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic checkAddr(input string what, input logic [MEM_ADDR_W-1:0] exp, input logic [MEM_ADDR_W-1:0] got);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkLen(input string what, input logic [BURST_LEN_W-1:0] exp, input logic [BURST_LEN_W-1:0] got);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp, input logic got);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic stop_test();
        if (fails == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one fetch, burst held for n cycles, then wait for idle
    task automatic fetch(input logic [MEM_ADDR_W-1:0] addr, input int n, input logic cancel);
        int k;
        @(posedge clock);
        #1;
        fetchStart = 1'b1;
        fetchAddr = addr;
        fetchBurst = (n > 0);
        fetchCancel = cancel;
        if (!cancel) begin
            expQ.push_back(addr);
        end
        @(posedge clock);
        #1;
        fetchStart = 1'b0;
        fetchCancel = 1'b0;
        repeat (n) @(posedge clock);
        #1;
        fetchBurst = 1'b0;
        for (k = 0; k < 60 && busy !== 1'b0; k++) begin
            @(posedge clock);
            #1;
        end
        checkBit("busy", 1'b0, busy);
        checkBit("burstLost", 1'b0, burstLost);
        repeat (3) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        #200us;
        fails++;
        stop_test();
    end

    // each access start takes the oldest noted address
    always @(negedge clock) begin
        if (srst === 1'b0) begin
            if (accessActive === 1'b1) begin
                if (prevAct !== 1'b1) begin
                    expLen = LEN_RESET;
                    if (expQ.size() == 0) begin
                        fails++;
                        $display("ERROR accessStart expected none seen %h", romAddr);
                    end else begin
                        expAddr = expQ.pop_front();
                    end
                end else begin
                    expAddr[CNT_W-1:0] = expAddr[CNT_W-1:0] + 8'h01;
                    expLen = expLen + 9'h001;
                end
                checkAddr("romAddr", expAddr, romAddr);
                checkBit("romCe_n", 1'b0, romCe_n);
                checkBit("romOe_n", 1'b0, romOe_n);
                checkBit("instr_valid_n", 1'b0, bus.instr_valid_n);
                checkBit("loadPulse", ~prevAct, loadPulse);
            end else begin
                if (prevAct === 1'b1) begin
                    expLen = expLen + 9'h001;
                end
                checkBit("romCe_n", 1'b1, romCe_n);
                checkBit("romOe_n", 1'b1, romOe_n);
                checkBit("loadPulse", 1'b0, loadPulse);
            end
            checkBit("wordValid", prevAct, wordValid);
            checkBit("resumePulse", 1'b0, resumePulse);
            checkLen("burstLen", expLen, burstLen);
            checkBit("burstOverrun", 1'b0, burstOverrun);
            prevAct = accessActive;
        end else begin
            prevAct = 1'b0;
            expLen = LEN_RESET;
        end
    end

    initial begin
        srst = 1'b1;
        fetchStart = 1'b0;
        fetchAddr = '0;
        fetchBurst = 1'b0;
        fetchCancel = 1'b0;
        fails = 0;
        checksDone = 0;
        lfsr = 16'he371;
        repeat (10) @(posedge clock);
        #1;
        srst = 1'b0;
        fetch(17'h123fc, 8, 1'b0);
        fetch(17'h00010, 0, 1'b0);
        fetch(17'h1ff11, 0, 1'b0);
        fetch(17'h0aa55, 3, 1'b1);
        fetch(17'h05501, 2, 1'b0);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsrNext(lfsr);
            fetch({lfsr[0], lfsr}, int'(lfsr[3:0]), 1'b0);
        end
        repeat (4) @(posedge clock);
        checkBit("queueEmpty", 1'b1, expQ.size() == 0);
        stop_test();
    end
endmodule
`default_nettype wire
